// ---- hdl/cmt_core_map.sv ----
// Instruction timing, boolean and exchange datapath, memory space decode.
// Assumes instruction class and memory requests arrive synchronous to core_clk.
`timescale 1ns/10ps
`include "cmt_defines.svh"

// Overview of operation
// - Accept up to one instruction per clock
// - Table of 109; none exceeds eight clocks
// - External and code byte moves: 1 byte, 3 clocks
// - Accumulator to indirect RAM: 1 byte, 2 clocks
// - Register exchange: 1 byte, 1 clock
// - Nibble exchange swaps low nibbles, 2 clocks
// - Jump if carry: 2 bytes, 2/3 clocks
// - Direct/immediate to direct: 3 bytes, 3 clocks
// - Data pointer load: 3 bytes, 3 clocks
// - Carry AND/OR with bit 2/2; clear/set/complement carry 1/1
// - 256 byte data, 8 kB program spaces
// - Flash spans 0x0000 to 0x207F
// - Factory range 0x1E00-0x1FFF never user-written
// - Write enable bit routes external writes to Flash
// - Flash read and written byte at a time
// - Lower 128 bytes direct and indirect
// - 0x00-0x1F four banks of eight registers
// - 0x20-0x2F bytes or 128 bits
// - Above 0x7F: direct SPECIAL_FUNCTION_REGISTER_SPACE, indirect upper RAM
// - Upper RAM never reached directly
// - 1024 byte external RAM via external moves
module cmt_core_map (
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  input  wire cmt_pkg::cmt_instr_s instr,
  output logic                    instr_ready,
  input  wire logic [7:0]         acc_in,
  input  wire logic [7:0]         ram_in,
  input  wire logic               bit_in,
  output logic                    issue_o,
  output logic [1:0]              len_o,
  output logic [3:0]              clocks_o,
  output logic [7:0]              acc_o,
  output logic [7:0]              ram_o,
  output logic                    ram_we_o,
  output logic                    bit_o,
  output logic                    bit_we_o,
  output logic                    carry_o,
  output logic                    jc_taken_o,
  input  wire cmt_pkg::cmt_mreq_s mreq,
  output cmt_pkg::cmt_msel_s      msel_o,
  output logic                    flash_we_o,
  output logic                    xram_we_o,
  output logic                    pswe_o
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic cmt_pkg::cmt_time_s time_of(input cmt_pkg::cmt_cls_e c);
    cmt_pkg::cmt_time_s t;
    t.len     = `CMT_L2;
    t.clk_min = `CMT_C2;
    t.clk_max = `CMT_C2;
    case (c)
      cmt_pkg::mov_rn_a, cmt_pkg::xch_rn, cmt_pkg::clr_c, cmt_pkg::setb_c,
      cmt_pkg::cpl_c: begin
        t.len     = `CMT_L1;
        t.clk_min = `CMT_C1;
        t.clk_max = `CMT_C1;
      end
      cmt_pkg::mov_dir_dir, cmt_pkg::mov_dir_imm, cmt_pkg::mov_data_pointer_imm: begin
        t.len     = `CMT_L3;
        t.clk_min = `CMT_C3;
        t.clk_max = `CMT_C3;
      end
      cmt_pkg::mov_ind_a, cmt_pkg::xch_ind, cmt_pkg::nibble_exchange_ind: begin
        t.len = `CMT_L1;
      end
      cmt_pkg::code_byte_move_data_pointer, cmt_pkg::code_byte_move_pc, cmt_pkg::external_data_move_rd_ind,
      cmt_pkg::external_data_move_wr_ind, cmt_pkg::external_data_move_rd_data_pointer, cmt_pkg::external_data_move_wr_data_pointer: begin
        t.len     = `CMT_L1;
        t.clk_min = `CMT_C3;
        t.clk_max = `CMT_C3;
      end
      cmt_pkg::jc_rel: begin
        t.clk_max = `CMT_C3;
      end
      default: begin
        t.len = `CMT_L2;
      end
    endcase
    return t;
  endfunction

  function automatic cmt_pkg::cmt_tgt_e low_tgt(input logic [7:0] a);
    cmt_pkg::cmt_tgt_e g;
    g = cmt_pkg::tg_low;
    if (a <= `CMT_BANK_TOP) begin
      g = cmt_pkg::tg_bank;
    end else if (a >= `CMT_BITRAM_BASE && a <= `CMT_BITRAM_TOP) begin
      g = cmt_pkg::tg_bitram;
    end
    return g;
  endfunction

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_sync_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_b <= rst_meta_r;
    end
  end

  // ****************************************
  // Issue sequencing
  // ****************************************
  cmt_pkg::cmt_st_e   st_r;
  logic [3:0]         cnt_r;
  cmt_pkg::cmt_time_s tm;
  logic [3:0]         eff_clk;
  logic               accept;

  assign tm          = time_of(instr.cls);
  assign eff_clk     = (instr.cls == cmt_pkg::jc_rel && carry_o) ? tm.clk_max : tm.clk_min;
  assign instr_ready = (st_r == cmt_pkg::st_idle);
  assign accept      = instr.valid && instr_ready;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r  <= cmt_pkg::st_idle;
      cnt_r <= 4'h0;
    end else begin
      case (st_r)
        cmt_pkg::st_idle: begin
          if (accept && eff_clk == `CMT_C2) begin
            st_r <= cmt_pkg::st_last;
          end else if (accept && eff_clk > `CMT_C2) begin
            st_r  <= cmt_pkg::st_busy;
            cnt_r <= eff_clk - `CMT_C2;
          end
        end
        cmt_pkg::st_busy: begin
          cnt_r <= cnt_r - `CMT_C1;
          if (cnt_r == `CMT_C1) begin
            st_r <= cmt_pkg::st_last;
          end
        end
        cmt_pkg::st_last: begin
          st_r <= cmt_pkg::st_idle;
        end
        default: begin
          st_r <= cmt_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      issue_o    <= 1'b0;
      len_o      <= 2'h0;
      clocks_o   <= 4'h0;
      jc_taken_o <= 1'b0;
    end else begin
      issue_o <= accept;
      if (accept) begin
        len_o      <= tm.len;
        clocks_o   <= eff_clk;
        jc_taken_o <= (instr.cls == cmt_pkg::jc_rel) && carry_o;
      end
    end
  end

  // ****************************************
  // Boolean unit
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      carry_o <= 1'b0;
    end else if (accept) begin
      case (instr.cls)
        cmt_pkg::clr_c:      carry_o <= 1'b0;
        cmt_pkg::setb_c:     carry_o <= 1'b1;
        cmt_pkg::cpl_c:      carry_o <= ~carry_o;
        cmt_pkg::anl_c_bit:  carry_o <= carry_o & bit_in;
        cmt_pkg::anl_c_nbit: carry_o <= carry_o & ~bit_in;
        cmt_pkg::orl_c_bit:  carry_o <= carry_o | bit_in;
        cmt_pkg::orl_c_nbit: carry_o <= carry_o | ~bit_in;
        cmt_pkg::mov_c_bit:  carry_o <= bit_in;
        default:             carry_o <= carry_o;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bit_o    <= 1'b0;
      bit_we_o <= 1'b0;
    end else begin
      bit_we_o <= accept && (instr.cls == cmt_pkg::clr_bit || instr.cls == cmt_pkg::setb_bit
                  || instr.cls == cmt_pkg::cpl_bit || instr.cls == cmt_pkg::mov_bit_c);
      if (accept) begin
        case (instr.cls)
          cmt_pkg::clr_bit:   bit_o <= 1'b0;
          cmt_pkg::setb_bit:  bit_o <= 1'b1;
          cmt_pkg::cpl_bit:   bit_o <= ~bit_in;
          cmt_pkg::mov_bit_c: bit_o <= carry_o;
          default:            bit_o <= bit_o;
        endcase
      end
    end
  end

  // ****************************************
  // Exchange datapath
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      acc_o    <= 8'h00;
      ram_o    <= 8'h00;
      ram_we_o <= 1'b0;
    end else begin
      ram_we_o <= 1'b0;
      if (accept) begin
        case (instr.cls)
          cmt_pkg::xch_rn, cmt_pkg::xch_dir, cmt_pkg::xch_ind: begin
            acc_o    <= ram_in;
            ram_o    <= acc_in;
            ram_we_o <= 1'b1;
          end
          cmt_pkg::nibble_exchange_ind: begin
            acc_o    <= {acc_in[7:4], ram_in[3:0]};
            ram_o    <= {ram_in[7:4], acc_in[3:0]};
            ram_we_o <= 1'b1;
          end
          cmt_pkg::mov_ind_a: begin
            ram_o    <= acc_in;
            ram_we_o <= 1'b1;
          end
          default: begin
            acc_o <= acc_o;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Program store control
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pswe_o <= 1'b0;
    end else if (mreq.valid && mreq.write && mreq.am == cmt_pkg::am_direct
                 && mreq.addr[7:0] == `CMT_PROGRAM_STORE_CONTROL_ADDR) begin
      pswe_o <= mreq.wdata[`CMT_PSWE_BIT];
    end
  end

  // ****************************************
  // Memory space decode
  // ****************************************
  cmt_pkg::cmt_msel_s sel_nxt;
  logic               flash_we_nxt;
  logic               xram_we_nxt;
  logic               in_fact;

  assign in_fact = mreq.addr >= `CMT_FACT_LO && mreq.addr <= `CMT_FACT_HI;

  always_comb begin
    sel_nxt        = '0;
    sel_nxt.valid  = mreq.valid;
    sel_nxt.write  = mreq.write;
    sel_nxt.wdata  = mreq.wdata;
    sel_nxt.index  = {8'h00, mreq.addr[7:0]};
    sel_nxt.tgt    = cmt_pkg::tg_none;
    flash_we_nxt   = 1'b0;
    xram_we_nxt    = 1'b0;
    case (mreq.am)
      cmt_pkg::am_direct: begin
        sel_nxt.tgt = (mreq.addr[7:0] > `CMT_LOW_TOP) ? cmt_pkg::tg_sfr
                      : low_tgt(mreq.addr[7:0]);
      end
      cmt_pkg::am_indirect: begin
        sel_nxt.tgt = (mreq.addr[7:0] > `CMT_LOW_TOP) ? cmt_pkg::tg_upper
                      : low_tgt(mreq.addr[7:0]);
      end
      cmt_pkg::am_wreg: begin
        sel_nxt.tgt   = cmt_pkg::tg_bank;
        sel_nxt.index = {11'h000, mreq.bank, mreq.addr[2:0]};
      end
      cmt_pkg::am_bit: begin
        sel_nxt.bitpos = mreq.addr[2:0];
        if (!mreq.addr[7]) begin
          sel_nxt.tgt   = cmt_pkg::tg_bitram;
          sel_nxt.index = {8'h00, `CMT_BITRAM_BASE + {4'h0, mreq.addr[6:3]}};
        end else begin
          sel_nxt.tgt   = cmt_pkg::tg_sfr;
          sel_nxt.index = {8'h00, mreq.addr[7:3], 3'h0};
        end
      end
      cmt_pkg::am_code: begin
        sel_nxt.index = mreq.addr;
        if (!mreq.write && mreq.addr <= `CMT_FLASH_TOP) begin
          sel_nxt.tgt = cmt_pkg::tg_flash;
        end
      end
      cmt_pkg::am_xdata: begin
        sel_nxt.index = mreq.addr;
        if (mreq.write && pswe_o) begin
          if (mreq.addr <= `CMT_FLASH_TOP && !in_fact) begin
            sel_nxt.tgt  = cmt_pkg::tg_flash;
            flash_we_nxt = mreq.valid;
          end
        end else if (`CMT_HAS_XRAM && mreq.addr <= `CMT_XRAM_TOP) begin
          sel_nxt.tgt = cmt_pkg::tg_xram;
          xram_we_nxt = mreq.valid && mreq.write;
        end
      end
      default: begin
        sel_nxt.tgt = cmt_pkg::tg_none;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      msel_o     <= '0;
      flash_we_o <= 1'b0;
      xram_we_o  <= 1'b0;
    end else begin
      msel_o     <= sel_nxt;
      flash_we_o <= flash_we_nxt;
      xram_we_o  <= xram_we_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_b);

  clock_max_a: assert property (issue_o |-> clocks_o <= `CMT_MAX_CLOCKS)
    else $error("instruction longer than eight clocks");
  external_data_move_time_a: assert property (accept && instr.cls == cmt_pkg::external_data_move_wr_data_pointer
    |=> len_o == `CMT_L1 && clocks_o == `CMT_C3 && !instr_ready ##1 !instr_ready ##1 instr_ready)
    else $error("external move timing wrong");
  xch_single_a: assert property (accept && instr.cls == cmt_pkg::xch_rn
    |=> instr_ready && clocks_o == `CMT_C1 && acc_o == $past(ram_in))
    else $error("register exchange not single clock");
  nibble_swap_a: assert property (accept && instr.cls == cmt_pkg::nibble_exchange_ind
    |=> acc_o == {$past(acc_in[7:4]), $past(ram_in[3:0])} && ram_we_o)
    else $error("nibble exchange result wrong");
  jc_taken_a: assert property (accept && instr.cls == cmt_pkg::jc_rel && carry_o
    |=> jc_taken_o && clocks_o == `CMT_C3 ##1 !instr_ready ##1 instr_ready)
    else $error("taken jump timing wrong");
  carry_and_a: assert property (accept && instr.cls == cmt_pkg::anl_c_nbit
    |=> carry_o == ($past(carry_o) & ~$past(bit_in)))
    else $error("carry and-not wrong");
  upper_ind_a: assert property (mreq.valid && mreq.am == cmt_pkg::am_indirect
    && mreq.addr[7:0] > `CMT_LOW_TOP |=> msel_o.tgt == cmt_pkg::tg_upper)
    else $error("indirect high address missed upper RAM");
  direct_sfr_a: assert property (mreq.valid && mreq.am == cmt_pkg::am_direct
    && mreq.addr[7:0] > `CMT_LOW_TOP |=> msel_o.tgt == cmt_pkg::tg_sfr)
    else $error("direct high address missed SPECIAL_FUNCTION_REGISTER_SPACE space");
  bit_map_a: assert property (mreq.valid && mreq.am == cmt_pkg::am_bit && !mreq.addr[7]
    |=> msel_o.index[7:0] == `CMT_BITRAM_BASE + {4'h0, $past(mreq.addr[6:3])})
    else $error("bit address mapped to wrong byte");
  flash_ro_a: assert property (mreq.valid && mreq.am == cmt_pkg::am_xdata && mreq.write
    && !pswe_o |=> !flash_we_o)
    else $error("flash written with write enable clear");
  factory_a: assert property (flash_we_o
    |-> !(msel_o.index >= `CMT_FACT_LO && msel_o.index <= `CMT_FACT_HI))
    else $error("factory range written");

  jc_taken_c: cover property (accept && instr.cls == cmt_pkg::jc_rel && carry_o);
  flash_wr_c: cover property (flash_we_o);
  upper_rd_c: cover property (msel_o.valid && msel_o.tgt == cmt_pkg::tg_upper);
  xram_wr_c:  cover property (xram_we_o);

endmodule

// ---- hdl/cmt_defines.svh ----
// Named constants for the core timing and memory map decoder.
// Assumes inclusion by bare name from the design file.
`ifndef CMT_DEFINES_SVH
`define CMT_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define CMT_MAX_SYS_MHZ   25
`define CMT_INSTR_COUNT   109
`define CMT_MAX_CLOCKS    4'h8
`define CMT_C1            4'h1
`define CMT_C2            4'h2
`define CMT_C3            4'h3
`define CMT_L1            2'h1
`define CMT_L2            2'h2
`define CMT_L3            2'h3

// ****************************************
// Internal data space
// ****************************************
`define CMT_IRAM_BYTES    256
`define CMT_LOW_TOP       8'h7F
`define CMT_BANK_TOP      8'h1F
`define CMT_BITRAM_BASE   8'h20
`define CMT_BITRAM_TOP    8'h2F
`define CMT_PROGRAM_STORE_CONTROL_ADDR    8'h8F
`define CMT_PSWE_BIT      0

// ****************************************
// Program and external data space
// ****************************************
`define CMT_PM_SPACE      16'h2000
`define CMT_FLASH_TOP     16'h207F
`define CMT_FACT_LO       16'h1E00
`define CMT_FACT_HI       16'h1FFF
`define CMT_XRAM_TOP      16'h03FF
`define CMT_HAS_XRAM      1'b1

`endif

// ---- hdl/cmt_pkg.sv ----
// Types shared by the core timing and memory map decoder.
// Assumes nothing of its surroundings.
package cmt_pkg;

  typedef enum logic [5:0] {
    mov_a_imm, mov_rn_a, mov_rn_dir, mov_rn_imm, mov_dir_a, mov_dir_rn,
    mov_dir_dir, mov_dir_ind, mov_dir_imm, mov_ind_a, mov_ind_dir, mov_ind_imm,
    mov_data_pointer_imm, code_byte_move_data_pointer, code_byte_move_pc, external_data_move_rd_ind, external_data_move_wr_ind, external_data_move_rd_data_pointer,
    external_data_move_wr_data_pointer, push_dir, pop_dir, xch_rn, xch_dir, xch_ind, nibble_exchange_ind,
    clr_c, clr_bit, setb_c, setb_bit, cpl_c, cpl_bit, anl_c_bit, anl_c_nbit,
    orl_c_bit, orl_c_nbit, mov_c_bit, mov_bit_c, jc_rel
  } cmt_cls_e;

  typedef enum logic [2:0] {
    am_direct, am_indirect, am_bit, am_wreg, am_code, am_xdata
  } cmt_am_e;

  typedef enum logic [2:0] {
    tg_none, tg_bank, tg_low, tg_bitram, tg_upper, tg_sfr, tg_flash, tg_xram
  } cmt_tgt_e;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_busy = 2'b01,
    st_last = 2'b11
  } cmt_st_e;

  typedef struct packed {
    logic     valid;
    cmt_cls_e cls;
  } cmt_instr_s;

  typedef struct packed {
    logic [1:0] len;
    logic [3:0] clk_min;
    logic [3:0] clk_max;
  } cmt_time_s;

  typedef struct packed {
    logic        valid;
    cmt_am_e     am;
    logic        write;
    logic [15:0] addr;
    logic [1:0]  bank;
    logic [7:0]  wdata;
  } cmt_mreq_s;

  typedef struct packed {
    logic        valid;
    cmt_tgt_e    tgt;
    logic        write;
    logic [15:0] index;
    logic [2:0]  bitpos;
    logic [7:0]  wdata;
  } cmt_msel_s;

endpackage

// ---- verif/cmt_mem_model.sv ----
// Behavioural program Flash and external RAM arrays behind the decoder.
// Assumes msel and write strobes arrive registered on core_clk.
`timescale 1ns/10ps

module cmt_mem_model (
  input  wire logic               core_clk,
  input  wire cmt_pkg::cmt_msel_s msel,
  input  wire logic               flash_we,
  input  wire logic               xram_we,
  output logic [7:0]              rdata
);
  // ****
  // Storage
  // ****
  logic [7:0] flash_mem [0:8319];
  logic [7:0] xram_mem  [0:1023];

  initial begin
    for (int i = 0; i < 8320; i++) flash_mem[i] = 8'hFF;
    for (int i = 0; i < 1024; i++) xram_mem[i] = 8'h00;
    rdata = 8'h00;
  end

  // ****
  // Byte writes
  // ****
  always @(posedge core_clk) begin
    if (flash_we && msel.index <= 16'h207F) flash_mem[msel.index[13:0]] <= msel.wdata;
    if (xram_we && msel.index <= 16'h03FF) xram_mem[msel.index[9:0]] <= msel.wdata;
  end

  // ****
  // Byte reads, last value inverted on each idle clock
  // ****
  always @(posedge core_clk) begin
    if (msel.valid && !msel.write && msel.tgt == cmt_pkg::tg_flash) begin
      rdata <= flash_mem[msel.index[13:0]];
    end else if (msel.valid && !msel.write && msel.tgt == cmt_pkg::tg_xram) begin
      rdata <= xram_mem[msel.index[9:0]];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the timing and memory map decoder.
// Assumes the package, decoder and memory model compile first.
`timescale 1ns/10ps

module tb_top;
  logic                core_clk;
  logic                rst_b;
  cmt_pkg::cmt_instr_s instr;
  logic                instr_ready;
  logic [7:0]          acc_in;
  logic [7:0]          ram_in;
  logic                bit_in;
  logic                issue_o;
  logic [1:0]          len_o;
  logic [3:0]          clocks_o;
  logic [7:0]          acc_o;
  logic [7:0]          ram_o;
  logic                ram_we_o;
  logic                bit_o;
  logic                bit_we_o;
  logic                carry_o;
  logic                jc_taken_o;
  cmt_pkg::cmt_mreq_s  mreq;
  cmt_pkg::cmt_msel_s  msel_o;
  logic                flash_we_o;
  logic                xram_we_o;
  logic                pswe_o;
  logic [7:0]          rdata;
  int                  num_errors;
  int                  n_tests;

  cmt_core_map u_cmt_core_map (
    .core_clk(core_clk), .rst_b(rst_b), .instr(instr), .instr_ready(instr_ready),
    .acc_in(acc_in), .ram_in(ram_in), .bit_in(bit_in), .issue_o(issue_o),
    .len_o(len_o), .clocks_o(clocks_o), .acc_o(acc_o), .ram_o(ram_o),
    .ram_we_o(ram_we_o), .bit_o(bit_o), .bit_we_o(bit_we_o), .carry_o(carry_o),
    .jc_taken_o(jc_taken_o), .mreq(mreq), .msel_o(msel_o),
    .flash_we_o(flash_we_o), .xram_we_o(xram_we_o), .pswe_o(pswe_o)
  );

  cmt_mem_model u_cmt_mem_model (
    .core_clk(core_clk), .msel(msel_o), .flash_we(flash_we_o),
    .xram_we(xram_we_o), .rdata(rdata)
  );

  always #5 core_clk = ~core_clk;

  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic ins(input cmt_pkg::cmt_cls_e c, input logic [7:0] a, input logic [7:0] r,
                     input logic b, input logic [1:0] el, input logic [3:0] ec);
    int n;
    @(posedge core_clk);
    instr <= '{valid: 1'b1, cls: c};
    acc_in <= a;
    ram_in <= r;
    bit_in <= b;
    @(posedge core_clk);
    instr.valid <= 1'b0;
    #1;
    chk(issue_o, 1'b1);
    chk(len_o, el);
    chk(clocks_o, ec);
    n = 1;
    while (instr_ready !== 1'b1 && n < 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(16'(n), ec);
    if (n >= 10) end_sim();
  endtask

  task automatic mem(input cmt_pkg::cmt_am_e m, input logic w, input logic [15:0] a,
                     input logic [1:0] bk, input logic [7:0] d, input cmt_pkg::cmt_tgt_e t,
                     input logic [15:0] ix, input logic fw, input logic xw);
    @(posedge core_clk);
    mreq <= '{valid: 1'b1, am: m, write: w, addr: a, bank: bk, wdata: d};
    @(posedge core_clk);
    mreq.valid <= 1'b0;
    #1;
    chk(msel_o.tgt, t);
    if (t != cmt_pkg::tg_none) chk(msel_o.index, ix);
    chk(flash_we_o, fw);
    chk(xram_we_o, xw);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic sc_timing();
    cmt_pkg::cmt_cls_e mv [6] = '{cmt_pkg::external_data_move_rd_ind, cmt_pkg::external_data_move_wr_ind,
      cmt_pkg::external_data_move_rd_data_pointer, cmt_pkg::external_data_move_wr_data_pointer, cmt_pkg::code_byte_move_data_pointer, cmt_pkg::code_byte_move_pc};
    foreach (mv[i]) ins(mv[i], 8'h00, 8'h00, 1'b0, 2'h1, 4'h3);
    ins(cmt_pkg::mov_ind_a, 8'h00, 8'h00, 1'b0, 2'h1, 4'h2);
    ins(cmt_pkg::mov_dir_dir, 8'h00, 8'h00, 1'b0, 2'h3, 4'h3);
    ins(cmt_pkg::mov_dir_imm, 8'h00, 8'h00, 1'b0, 2'h3, 4'h3);
    ins(cmt_pkg::mov_data_pointer_imm, 8'h00, 8'h00, 1'b0, 2'h3, 4'h3);
  endtask

  task automatic sc_exchange();
    ins(cmt_pkg::xch_rn, 8'hA5, 8'h3C, 1'b0, 2'h1, 4'h1);
    chk(ram_we_o, 1'b1);
    chk({acc_o, ram_o}, 16'h3CA5);
    ins(cmt_pkg::nibble_exchange_ind, 8'hA5, 8'h3C, 1'b0, 2'h1, 4'h2);
    chk({acc_o, ram_o}, 16'hAC35);
  endtask

  task automatic sc_bool();
    ins(cmt_pkg::setb_c, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1);
    chk(carry_o, 1'b1);
    ins(cmt_pkg::anl_c_bit, 8'h00, 8'h00, 1'b0, 2'h2, 4'h2);
    chk(carry_o, 1'b0);
    ins(cmt_pkg::setb_c, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1);
    ins(cmt_pkg::anl_c_nbit, 8'h00, 8'h00, 1'b0, 2'h2, 4'h2);
    chk(carry_o, 1'b1);
    ins(cmt_pkg::clr_c, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1);
    chk(carry_o, 1'b0);
    ins(cmt_pkg::orl_c_bit, 8'h00, 8'h00, 1'b1, 2'h2, 4'h2);
    chk(carry_o, 1'b1);
    ins(cmt_pkg::clr_c, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1);
    ins(cmt_pkg::orl_c_nbit, 8'h00, 8'h00, 1'b1, 2'h2, 4'h2);
    chk(carry_o, 1'b0);
    ins(cmt_pkg::cpl_c, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1);
    chk(carry_o, 1'b1);
    ins(cmt_pkg::cpl_bit, 8'h00, 8'h00, 1'b1, 2'h2, 4'h2);
    chk(bit_o, 1'b0);
    chk(bit_we_o, 1'b0);
    ins(cmt_pkg::mov_bit_c, 8'h00, 8'h00, 1'b0, 2'h2, 4'h2);
    chk(bit_o, 1'b1);
    ins(cmt_pkg::clr_bit, 8'h00, 8'h00, 1'b1, 2'h2, 4'h2);
    chk(bit_o, 1'b0);
    ins(cmt_pkg::setb_bit, 8'h00, 8'h00, 1'b0, 2'h2, 4'h2);
    chk(bit_o, 1'b1);
  endtask

  task automatic sc_jump();
    ins(cmt_pkg::jc_rel, 8'h00, 8'h00, 1'b0, 2'h2, 4'h3);
    chk(jc_taken_o, 1'b1);
    ins(cmt_pkg::clr_c, 8'h00, 8'h00, 1'b0, 2'h1, 4'h1);
    ins(cmt_pkg::jc_rel, 8'h00, 8'h00, 1'b0, 2'h2, 4'h2);
    chk(jc_taken_o, 1'b0);
  endtask

  task automatic sc_map();
    mem(cmt_pkg::am_direct, 1'b0, 16'h0010, 2'h0, 8'h00, cmt_pkg::tg_bank, 16'h0010, 0, 0);
    mem(cmt_pkg::am_wreg, 1'b0, 16'h0005, 2'h2, 8'h00, cmt_pkg::tg_bank, 16'h0015, 0, 0);
    mem(cmt_pkg::am_direct, 1'b0, 16'h0025, 2'h0, 8'h00, cmt_pkg::tg_bitram, 16'h0025, 0, 0);
    mem(cmt_pkg::am_bit, 1'b0, 16'h000B, 2'h0, 8'h00, cmt_pkg::tg_bitram, 16'h0021, 0, 0);
    chk(msel_o.bitpos, 3'h3);
    mem(cmt_pkg::am_direct, 1'b0, 16'h0050, 2'h0, 8'h00, cmt_pkg::tg_low, 16'h0050, 0, 0);
    mem(cmt_pkg::am_indirect, 1'b0, 16'h007F, 2'h0, 8'h00, cmt_pkg::tg_low, 16'h007F, 0, 0);
    mem(cmt_pkg::am_direct, 1'b0, 16'h0090, 2'h0, 8'h00, cmt_pkg::tg_sfr, 16'h0090, 0, 0);
    mem(cmt_pkg::am_indirect, 1'b0, 16'h0080, 2'h0, 8'h00, cmt_pkg::tg_upper, 16'h0080, 0, 0);
  endtask

  task automatic sc_flash();
    mem(cmt_pkg::am_direct, 1'b1, 16'h008F, 2'h0, 8'h01, cmt_pkg::tg_sfr, 16'h008F, 0, 0);
    chk(pswe_o, 1'b1);
    mem(cmt_pkg::am_xdata, 1'b1, 16'h0100, 2'h0, 8'hD7, cmt_pkg::tg_flash, 16'h0100, 1, 0);
    mem(cmt_pkg::am_xdata, 1'b1, 16'h207F, 2'h0, 8'h11, cmt_pkg::tg_flash, 16'h207F, 1, 0);
    mem(cmt_pkg::am_xdata, 1'b1, 16'h2080, 2'h0, 8'h22, cmt_pkg::tg_none, 16'h0000, 0, 0);
    mem(cmt_pkg::am_xdata, 1'b1, 16'h1E10, 2'h0, 8'h33, cmt_pkg::tg_none, 16'h0000, 0, 0);
    mem(cmt_pkg::am_code, 1'b0, 16'h207F, 2'h0, 8'h00, cmt_pkg::tg_flash, 16'h207F, 0, 0);
    mem(cmt_pkg::am_code, 1'b1, 16'h0100, 2'h0, 8'h44, cmt_pkg::tg_none, 16'h0000, 0, 0);
    @(posedge core_clk);
    #1;
    chk(rdata, 8'h11);
    chk(u_cmt_mem_model.flash_mem[16'h0100], 8'hD7);
    mem(cmt_pkg::am_direct, 1'b1, 16'h008F, 2'h0, 8'h00, cmt_pkg::tg_sfr, 16'h008F, 0, 0);
    chk(pswe_o, 1'b0);
    mem(cmt_pkg::am_xdata, 1'b1, 16'h0100, 2'h0, 8'h5A, cmt_pkg::tg_xram, 16'h0100, 0, 1);
    mem(cmt_pkg::am_xdata, 1'b1, 16'h03FF, 2'h0, 8'h66, cmt_pkg::tg_xram, 16'h03FF, 0, 1);
    mem(cmt_pkg::am_xdata, 1'b1, 16'h0400, 2'h0, 8'h77, cmt_pkg::tg_none, 16'h0000, 0, 0);
    chk(u_cmt_mem_model.flash_mem[16'h0100], 8'hD7);
    chk(u_cmt_mem_model.xram_mem[10'h100], 8'h5A);
    chk(u_cmt_mem_model.xram_mem[10'h3FF], 8'h66);
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    instr = '0;
    acc_in = 8'h00;
    ram_in = 8'h00;
    bit_in = 1'b0;
    mreq = '0;
    num_errors = 0;
    n_tests = 0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(instr_ready, 1'b1);
    chk(pswe_o, 1'b0);
    sc_timing();
    sc_exchange();
    sc_bool();
    sc_jump();
    sc_map();
    sc_flash();
    end_sim();
  end
endmodule
